// *** hdl/cpc_clock_pll_controller.sv ***
// Purpose: Clock controller with digital frequency synthesiser model
// Assumes: Oscillator pin sampled on aclk, toggling far below aclk
// Notes:   Clock outputs are one-cycle enable pulses on aclk
//
// Functional notes
// - Make three clocks: CPU core, peripherals, USB controller.
// - Gate each clock according to the power reduction mode.
// - Oscillator input may carry an external 48 MHz clock instead.
// - Oscillator inverter off when synthesiser not feeding USB.
// - Synthesiser enable bit starts generation; clearing it stops.
// - Lock flag set once the loop has locked.
// - Phase detector compares N reference with R feedback, up/down.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module cpc_clock_pll_controller
#(
  parameter int LOCK_COUNT = cpc_pkg::LOCK_REFS
)
(
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write
  input  wire logic [cpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [cpc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Oscillator pins
  input  wire logic                      osc_input_pin,
  output logic                           osc_output_pin,
  output logic                           osc_output_en,
  // Generated clock enables
  output logic                           cpu_clk_en,
  output logic                           periph_clk_en,
  output logic                           usb_clk_en,
  // Phase detector
  output logic                           phase_up,
  output logic                           phase_down
);
  import cpc_pkg::*;

  initial
  begin
    if (LOCK_COUNT < 1 || LOCK_COUNT > 255)
      $error("LOCK_COUNT out of range");
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic [ADDR_W-1:0] aw_addr_ff;
  logic              aw_held_ff;
  logic [7:0]        w_data_ff;
  logic              w_en_ff;
  logic              w_held_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        clock_double_control_0_ff;
  logic [7:0]        clock_double_control_1_ff;
  logic [7:0]        pwr_ff;
  logic              external_48m_select_ff;
  logic              en_ff;
  logic [7:0]        div_ff;
  cpc_lock_state_t   state_ff;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire [7:0] w_idx = aw_addr_ff[ADDR_W-1:2];
  wire [7:0] r_idx = s_axi_araddr[ADDR_W-1:2];
  wire wr_ck0  = do_wr & w_en_ff & (w_idx == IDX_CLOCK_DOUBLE_CONTROL_0);
  wire wr_ck1  = do_wr & w_en_ff & (w_idx == IDX_CLOCK_DOUBLE_CONTROL_1);
  wire wr_pwr  = do_wr & w_en_ff & (w_idx == IDX_PWR);
  wire wr_ctl  = do_wr & w_en_ff & (w_idx == IDX_SYNCTL);
  wire wr_div  = do_wr & w_en_ff & (w_idx == IDX_SYNDIV);
  wire w_hit   = (w_idx == IDX_CLOCK_DOUBLE_CONTROL_0) | (w_idx == IDX_CLOCK_DOUBLE_CONTROL_1) |
                 (w_idx == IDX_PWR) | (w_idx == IDX_SYNCTL) |
                 (w_idx == IDX_SYNDIV);
  wire locked  = (state_ff == CPC_LOCK);
  wire [7:0] ctl_rd = {5'h00, external_48m_select_ff, en_ff, locked};
  wire r_hit   = (r_idx == IDX_CLOCK_DOUBLE_CONTROL_0) | (r_idx == IDX_CLOCK_DOUBLE_CONTROL_1) |
                 (r_idx == IDX_PWR) | (r_idx == IDX_SYNCTL) |
                 (r_idx == IDX_SYNDIV);
  wire [7:0] r_val = (r_idx == IDX_CLOCK_DOUBLE_CONTROL_0) ? clock_double_control_0_ff :
                     (r_idx == IDX_CLOCK_DOUBLE_CONTROL_1) ? clock_double_control_1_ff :
                     (r_idx == IDX_PWR)    ? pwr_ff    :
                     (r_idx == IDX_SYNCTL) ? ctl_rd    :
                     (r_idx == IDX_SYNDIV) ? div_ff    : 8'h00;

  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= 8'h00;
      w_en_ff    <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_ff <= s_axi_wdata[7:0];
        w_en_ff   <= s_axi_wstrb[0];
      end
      aw_held_ff <= (aw_held_ff | aw_take) & ~do_wr;
      w_held_ff  <= (w_held_ff | w_take) & ~do_wr;
      if (do_wr)
        bresp_ff <= w_hit ? RESP_OKAY : RESP_SLVERR;
      bvalid_ff <= do_wr | (bvalid_ff & ~s_axi_bready);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, r_val};
      rresp_ff  <= r_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_double_control_0_ff <= REG_RST;
      clock_double_control_1_ff <= REG_RST;
      pwr_ff    <= REG_RST;
      div_ff    <= REG_RST;
      external_48m_select_ff  <= 1'b0;
      en_ff     <= 1'b0;
    end
    else
    begin
      if (wr_ck0)
        clock_double_control_0_ff <= w_data_ff;
      if (wr_ck1)
        clock_double_control_1_ff <= w_data_ff;
      if (wr_pwr)
        pwr_ff <= w_data_ff;
      if (wr_div)
        div_ff <= w_data_ff;
      if (wr_ctl)
      begin
        external_48m_select_ff <= w_data_ff[EXTERNAL_48M_SELECT_BIT];
        en_ff    <= w_data_ff[EN_BIT];
      end
    end
  end

  // ****************************************
  // Oscillator and clock gating
  // ****************************************
  logic osc_prev_ff;
  logic half_ff;
  logic synth_pulse_ff;
  logic cpu_ff;
  logic per_ff;
  logic usb_ff;
  logic oout_ff;

  wire osc_tick  = osc_input_pin & ~osc_prev_ff;
  wire idle      = pwr_ff[IDLE_BIT];
  wire pdown     = pwr_ff[PD_BIT];
  // X2 passes every rising oscillator edge, otherwise every second one
  wire base_tick = osc_tick & (clock_double_control_0_ff[X2_BIT] | half_ff);
  wire usb_src   = external_48m_select_ff ? osc_tick : synth_pulse_ff;
  wire inv_on    = ~external_48m_select_ff;

  assign cpu_clk_en     = cpu_ff;
  assign periph_clk_en  = per_ff;
  assign usb_clk_en     = usb_ff;
  assign osc_output_pin = oout_ff;
  assign osc_output_en  = inv_on;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_prev_ff <= 1'b0;
      half_ff     <= 1'b0;
      oout_ff     <= 1'b0;
      cpu_ff      <= 1'b0;
      per_ff      <= 1'b0;
      usb_ff      <= 1'b0;
    end
    else
    begin
      osc_prev_ff <= osc_input_pin;
      oout_ff     <= ~osc_input_pin & inv_on;
      if (osc_tick)
        half_ff <= ~half_ff;
      cpu_ff <= base_tick & ~idle & ~pdown;
      per_ff <= base_tick & ~pdown;
      usb_ff <= usb_src & ~pdown;
    end
  end

  // ****************************************
  // Synthesiser: dividers, phase detector, lock
  // ****************************************
  logic [3:0]          ref_cnt_ff;
  logic [3:0]          fb_cnt_ff;
  logic [CREDIT_W-1:0] credit_ff;
  logic [2:0]          diff_ff;
  logic [7:0]          lock_cnt_ff;

  wire [3:0] r_fld   = div_ff[R_MSB:R_LSB];
  wire [3:0] n_fld   = div_ff[N_MSB:N_LSB];
  wire run           = en_ff & ~wr_div;
  wire ref_pulse     = run & osc_tick & (ref_cnt_ff == n_fld);
  wire nxt_pulse     = run & (credit_ff != '0);
  wire fb_pulse      = synth_pulse_ff & (fb_cnt_ff == r_fld);
  wire [CREDIT_W-1:0] add_val = ref_pulse ?
                       CREDIT_W'({1'b0, r_fld} + 5'h01) : '0;
  // Saturate rather than wrap if the oscillator runs too fast
  wire [CREDIT_W:0] sum = {1'b0, credit_ff} + {1'b0, add_val} -
                          {{CREDIT_W{1'b0}}, nxt_pulse};
  wire [CREDIT_W-1:0] nxt_credit = sum[CREDIT_W] ? '1 :
                                   sum[CREDIT_W-1:0];
  wire signed [2:0] diff = diff_ff;
  wire near_zero   = (diff >= -3'sd1) && (diff <= 3'sd1);
  wire [2:0] nxt_diff = (ref_pulse & ~fb_pulse & diff != 3'sd3) ?
                        diff_ff + 3'h1 :
                        (fb_pulse & ~ref_pulse & diff != 3'sh4) ?
                        diff_ff - 3'h1 : diff_ff;

  assign phase_up   = diff > 3'sd0;
  assign phase_down = diff < 3'sd0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      ref_cnt_ff     <= 4'h0;
      fb_cnt_ff      <= 4'h0;
      credit_ff      <= '0;
      diff_ff        <= 3'h0;
      synth_pulse_ff <= 1'b0;
    end
    else
    begin
      if (osc_tick)
        ref_cnt_ff <= (ref_cnt_ff == n_fld) ? 4'h0 : ref_cnt_ff + 4'h1;
      if (synth_pulse_ff)
        fb_cnt_ff <= (fb_cnt_ff == r_fld) ? 4'h0 : fb_cnt_ff + 4'h1;
      credit_ff      <= nxt_credit;
      synth_pulse_ff <= nxt_pulse;
      diff_ff        <= nxt_diff;
    end
  end

  cpc_lock_state_t nxt_state;
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      CPC_OFF:  nxt_state = CPC_ACQ;
      CPC_ACQ:
        if (ref_pulse && near_zero &&
            lock_cnt_ff == 8'(LOCK_COUNT - 1))
          nxt_state = CPC_LOCK;
      CPC_LOCK:
        if (!near_zero)
          nxt_state = CPC_ACQ;
      default:  nxt_state = CPC_OFF;
    endcase
    if (!run)
      nxt_state = CPC_OFF;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff    <= CPC_OFF;
      lock_cnt_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      if (!run || !near_zero || nxt_state != CPC_ACQ)
        lock_cnt_ff <= 8'h00;
      else if (ref_pulse)
        lock_cnt_ff <= lock_cnt_ff + 8'h01;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence lock_done_s;
    ref_pulse && near_zero && state_ff == CPC_ACQ &&
    lock_cnt_ff == 8'(LOCK_COUNT - 1);
  endsequence

  three_clocks_a: assert property (
    base_tick && idle && !pdown |=> per_ff && !cpu_ff)
    else $error("idle must stop only the core clock");
  power_gate_a: assert property (
    pdown |=> !cpu_ff && !per_ff && !usb_ff)
    else $error("power-down left a clock running");
  ext_source_a: assert property (
    external_48m_select_ff && osc_tick && !pdown |=> usb_ff)
    else $error("external clock did not reach usb");
  osc_off_a: assert property (
    external_48m_select_ff |-> !osc_output_en ##1 !oout_ff)
    else $error("inverter active without synthesiser");
  synth_stop_a: assert property (
    !en_ff |=> !synth_pulse_ff [*2])
    else $error("synthesiser ran while disabled");
  lock_set_a: assert property (
    lock_done_s |=> locked && ctl_rd[LOCK_BIT])
    else $error("lock flag not set on lock");
  phase_dir_a: assert property (
    run && diff_ff == 3'h0 && ref_pulse && !fb_pulse |=> phase_up)
    else $error("phase detector missed up pulse");
  synth_rate_a: assert property (
    run && ref_pulse && credit_ff == '0 |=>
      credit_ff == CREDIT_W'({1'b0, $past(r_fld)} + 5'h01))
    else $error("credit not R plus one per reference");
  lock_clear_a: assert property (
    wr_div || !en_ff |=> !locked)
    else $error("lock flag survived disable or rewrite");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule

// *** hdl/cpc_pkg.sv ***
// Purpose: Constants for the clock and synthesiser controller
// Assumes: Registers sit at byte address four times their index
// Notes:   Reset values of all control registers are zero
package cpc_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int         ADDR_W      = 10;
  localparam logic [7:0] IDX_CLOCK_DOUBLE_CONTROL_0  = 8'h8f;
  localparam logic [7:0] IDX_SYNCTL  = 8'ha3;
  localparam logic [7:0] IDX_SYNDIV  = 8'ha4;
  localparam logic [7:0] IDX_CLOCK_DOUBLE_CONTROL_1  = 8'haf;
  localparam logic [7:0] IDX_PWR     = 8'h87;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         EXTERNAL_48M_SELECT_BIT   = 2;
  localparam int         EN_BIT      = 1;
  localparam int         LOCK_BIT    = 0;
  localparam int         X2_BIT      = 0;
  localparam int         IDLE_BIT    = 0;
  localparam int         PD_BIT      = 1;
  localparam int         R_MSB       = 7;
  localparam int         R_LSB       = 4;
  localparam int         N_MSB       = 3;
  localparam int         N_LSB       = 0;
  localparam logic [7:0] REG_RST     = 8'h00;
  // ****************************************
  // Timing counts
  // ****************************************
  localparam int         LOCK_REFS   = 8;
  localparam int         CREDIT_W    = 8;
  // ****************************************
  // Lock tracking states, Gray along the path
  // ****************************************
  typedef enum logic [1:0] {
    CPC_OFF  = 2'b00,
    CPC_ACQ  = 2'b01,
    CPC_LOCK = 2'b11
  } cpc_lock_state_t;
endpackage

// *** sim/cpc_osc_model.sv ***
// Purpose: Crystal or external 48 MHz source on the oscillator input
// Assumes: Toggles once every HALF aclk cycles while run is high
// Notes:   Stands still at low between bursts
`timescale 1ns/1ps
module cpc_osc_model
#(
  parameter int HALF = 10
)
(
  // Clock
  input  wire logic aclk,
  // Control
  input  wire logic run,
  // Oscillator pin
  output logic      osc_out
);
  int cnt_ff;
  // Same pin model serves crystal and external clock alike
  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      cnt_ff  <= 0;
      osc_out <= 1'b0;
    end
    else if (cnt_ff == HALF - 1)
    begin
      cnt_ff  <= 0;
      osc_out <= ~osc_out;
    end
    else
      cnt_ff <= cnt_ff + 1;
  end
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the clock and synthesiser controller
// Assumes: Oscillator model ticks every 20 aclk cycles
// Notes:   Lock count shortened to 2 reference pulses
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  error_cnt++; $display("Error at %0t got %h exp %h", $time, a, b); end end
module tb;
  import cpc_pkg::*;
  logic              aclk, aresetn, run, osc_pin, osc_out, osc_en, up, dn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              cpu_en, per_en, usb_en;
  logic [31:0]       wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r;
  logic [7:0]        t_map [5] = '{IDX_CLOCK_DOUBLE_CONTROL_0, IDX_SYNCTL, IDX_SYNDIV,
                                   IDX_CLOCK_DOUBLE_CONTROL_1, IDX_PWR};
  logic [7:0]        t_x2 [5] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
  logic [7:0]        t_pw [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h02};
  logic [7:0]        t_ct [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
  int                t_cpu [5] = '{4, 8, 0, 4, 0};
  int                t_per [5] = '{4, 8, 8, 4, 0};
  int                t_usb [5] = '{0, 0, 0, 8, 0};
  logic [7:0]        t_div [2] = '{8'h30, 8'hb9};
  int                error_cnt, total_checks, cyc, ticks, k, e;
  int                n_cpu, n_per, n_usb, n_up;
  logic              pin_last, en_last, rst_last;

  cpc_osc_model #(.HALF(10)) u_cpc_osc_model (.aclk(aclk), .run(run),
    .osc_out(osc_pin));
  cpc_clock_pll_controller #(.LOCK_COUNT(2)) u_cpc_clock_pll_controller (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_input_pin(osc_pin),
    .osc_output_pin(osc_out), .osc_output_en(osc_en), .cpu_clk_en(cpu_en),
    .periph_clk_en(per_en), .usb_clk_en(usb_en), .phase_up(up),
    .phase_down(dn));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****************************************
  // Pulse counting, off the sampling edge to avoid races
  // ****************************************
  always @(negedge aclk)
  begin
    n_cpu += int'(cpu_en === 1'b1);
    n_per += int'(per_en === 1'b1);
    n_usb += int'(usb_en === 1'b1);
    n_up  += int'(up === 1'b1);
    if (up === 1'b1 && dn === 1'b1)
      `CHK({up, dn}, 2'b01)
    // Inverter output is the pin inverted a cycle late, or held low
    if (aresetn === 1'b1 && rst_last === 1'b1)
      `CHK(osc_out, ~pin_last & en_last)
    pin_last = osc_pin;
    en_last  = osc_en;
    rst_last = aresetn;
  end
  always @(posedge osc_pin)
    ticks++;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic aw_hs, w_hs, b_hs;
    awaddr  <= {i, 2'b00};
    wdata   <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Handshakes judged on settled values, acted on at the next edge
    do
    begin
      @(negedge aclk);
      aw_hs = awvalid & (awready === 1'b1);
      w_hs  = wvalid & (wready === 1'b1);
      b_hs  = (bvalid === 1'b1);
      r     = bresp;
      @(posedge aclk);
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
    end
    while (!b_hs);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] i);
    logic ar_hs, r_hs;
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar_hs = arvalid & (arready === 1'b1);
      r_hs  = (rvalid === 1'b1);
      d     = rdata;
      r     = rresp;
      @(posedge aclk);
      if (ar_hs)
        arvalid <= 1'b0;
    end
    while (!r_hs);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] i, input logic [31:0] v,
                      input logic [1:0] er);
    rd(i);
    `CHK(d, v)
    `CHK(r, er)
  endtask

  // Burst of n ticks, then a pause long enough to drain synth credits
  task automatic run_ticks(input int n);
    int t0;
    t0 = ticks;
    run <= 1'b1;
    while (ticks < t0 + n)
      @(posedge aclk);
    run <= 1'b0;
    repeat (60) @(posedge aclk);
  endtask

  initial
  begin
    {aresetn, run, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(osc_en, 1'b1)
    for (int i = 0; i < 5; i++)
      rchk(t_map[i], {24'h000000, REG_RST}, RESP_OKAY);
    rchk(8'h10, 32'h00000000, RESP_SLVERR);
    wr(8'h10, 8'h55);
    `CHK(r, RESP_SLVERR)
    wr(IDX_CLOCK_DOUBLE_CONTROL_1, 8'h5a);
    rchk(IDX_CLOCK_DOUBLE_CONTROL_1, 32'h0000005a, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      wr(IDX_CLOCK_DOUBLE_CONTROL_0, t_x2[i]);
      wr(IDX_PWR, t_pw[i]);
      wr(IDX_SYNCTL, t_ct[i]);
      `CHK(osc_en, ~t_ct[i][EXTERNAL_48M_SELECT_BIT])
      {n_cpu, n_per, n_usb} = '0;
      run_ticks(8);
      `CHK(n_cpu, t_cpu[i])
      `CHK(n_per, t_per[i])
      `CHK(n_usb, t_usb[i])
    end
    wr(IDX_PWR, 8'h00);
    wr(IDX_SYNCTL, 8'h00);
    $display("test clock gating done");
    for (int i = 0; i < 2; i++)
    begin
      wr(IDX_SYNDIV, t_div[i]);
      rchk(IDX_SYNDIV, {24'h000000, t_div[i]}, RESP_OKAY);
      wr(IDX_SYNCTL, 8'h02);
      run <= 1'b1;
      k = 0;
      do
      begin
        rd(IDX_SYNCTL);
        k++;
      end
      while (d[LOCK_BIT] !== 1'b1 && k < 400);
      run <= 1'b0;
      `CHK(d[LOCK_BIT], 1'b1)
      repeat (60) @(posedge aclk);
      {n_cpu, n_per, n_usb} = '0;
      n_up = 0;
      run_ticks(20);
      e = 20 * (int'(t_div[i][R_MSB:R_LSB]) + 1)
        / (int'(t_div[i][N_MSB:N_LSB]) + 1);
      `CHK(n_usb, e)
      `CHK(n_up > 0, 1'b1)
      wr(IDX_SYNDIV, t_div[i]);
      rchk(IDX_SYNCTL, 32'h00000002, RESP_OKAY);
      wr(IDX_SYNCTL, 8'h00);
      {n_cpu, n_per, n_usb} = '0;
      run_ticks(20);
      `CHK(n_usb, 0)
      `CHK({up, dn}, 2'b00)
      rchk(IDX_SYNCTL, 32'h00000000, RESP_OKAY);
    end
    $display("test synthesiser done");
    results();
  end
endmodule
